// *** src/asrd_ctrl.sv ***
/*
  Setup-command tail: reference power sequencing in external-clock mode and
  channel-pair register loading selected by the pair-config field.
  Assumes a decoded setup byte arriving as a one-cycle strobe on ref_clk, and
  serial clock, chip select and data in taken straight from the pins.
*/
// How it works
// - Mode 11: delays counted in serial clocks
// - Internal ref off after scan; 218-cycle wake
// - Temperature measurement forces internal reference on
// - Temperature waits 244 cycles for reference settling
// - Temperature result ready after 188 more cycles
// - Ref select 01/11: no internal ref, no wake
// - Ref select 10 default, internal like 00
// - Pair select 00/01: no data byte expected
// - Pair select 00/01: pair registers unchanged
// - Pair select 10 loads unipolar register
// - Pair select 11 loads bipolar register
// - Unexpected following byte is a new command
// - Unipolar bits 7..4 select pairs 01..67
// - Pair registers reset to zero
`timescale 1ns/1ps
`include "asrd_consts.svh"
module asrd_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       din_pin,
  input  wire logic       setup_strobe,
  input  wire logic [7:0] setup_byte,
  input  wire logic       conv_request,
  input  wire logic       conv_is_temp,
  input  wire logic       scan_done,
  output logic            cmd_byte_valid,
  output logic [7:0]      cmd_byte,
  output logic            conv_start,
  output logic            temp_result_ready,
  output logic            int_ref_on,
  output logic            ref_pin_is_input,
  output logic [1:0]      conv_clock_select,
  output logic [7:0]      unipolar_pair_config,
  output logic [7:0]      bipolar_pair_config,
  output logic            uni_diff_pair01,
  output logic            uni_diff_pair23,
  output logic            uni_diff_pair45,
  output logic            uni_diff_pair67,
  output logic            busy
);
  logic             sclk_rise;
  logic             cs_n_lvl;
  logic             cs_fall;
  logic             din_lvl;
  logic [1:0]       ref_select;
  logic             pair_cfg_select_hi;
  logic             pair_cfg_select_lo;
  logic [1:0]       pair_target;
  asrd_pkg::asrd_rx_t  rx_state;
  logic [2:0]       bit_cnt;
  logic [7:0]       shift;
  asrd_pkg::asrd_seq_t seq_state;
  logic [8:0]       cyc_cnt;
  logic             ref_warm;

  function automatic logic ref_is_internal(input logic [1:0] sel);
    ref_is_internal = (sel == `ASRD_REFSEL_INT) || (sel == `ASRD_REFSEL_DEFAULT);
  endfunction

  asrd_sync u_sclk (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (sclk_pin),
    .level    (),
    .rise     (sclk_rise),
    .fall     ()
  );

  asrd_sync u_cs (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (cs_n_pin),
    .level    (cs_n_lvl),
    .rise     (),
    .fall     (cs_fall)
  );

  asrd_sync u_din (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (din_pin),
    .level    (din_lvl),
    .rise     (),
    .fall     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Setup fields

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_clock_select  <= `ASRD_CKSEL_RESET;
      ref_select         <= `ASRD_REFSEL_DEFAULT;
      pair_cfg_select_hi <= 1'b0;
      pair_cfg_select_lo <= 1'b0;
    end else if (setup_strobe) begin
      conv_clock_select  <= setup_byte[`ASRD_SETUP_CKSEL_HI:`ASRD_SETUP_CKSEL_LO];
      ref_select         <= setup_byte[`ASRD_SETUP_REFSEL_HI:`ASRD_SETUP_REFSEL_LO];
      pair_cfg_select_hi <= setup_byte[`ASRD_SETUP_DIFF_HI];
      pair_cfg_select_lo <= setup_byte[`ASRD_SETUP_DIFF_LO];
    end
  end

  assign ref_pin_is_input = ref_is_internal(ref_select);
  assign pair_target      = {pair_cfg_select_hi, pair_cfg_select_lo};

  ////////////////////////////////////////////////////////////////////////////
  // Serial byte receiver

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= asrd_pkg::ASRD_RX_CMD;
    end else if (setup_strobe) begin
      rx_state <= setup_byte[`ASRD_SETUP_DIFF_HI] ? asrd_pkg::ASRD_RX_DATA
                                                  : asrd_pkg::ASRD_RX_CMD;
    end else if (cs_n_lvl) begin
      rx_state <= asrd_pkg::ASRD_RX_CMD;
    end else if (sclk_rise && bit_cnt == 3'h7) begin
      rx_state <= asrd_pkg::ASRD_RX_CMD;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 3'h0;
      shift   <= 8'h00;
    end else if (cs_n_lvl || cs_fall) begin
      bit_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= {shift[6:0], din_lvl};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_byte_valid <= 1'b0;
      cmd_byte       <= 8'h00;
    end else begin
      cmd_byte_valid <= 1'b0;
      if (!cs_n_lvl && sclk_rise && bit_cnt == 3'h7 &&
          rx_state == asrd_pkg::ASRD_RX_CMD && !setup_strobe) begin
        cmd_byte_valid <= 1'b1;
        cmd_byte       <= {shift[6:0], din_lvl};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel-pair registers

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unipolar_pair_config <= `ASRD_PAIR_RESET;
      bipolar_pair_config  <= `ASRD_PAIR_RESET;
    end else if (!cs_n_lvl && sclk_rise && bit_cnt == 3'h7 &&
                 rx_state == asrd_pkg::ASRD_RX_DATA && !setup_strobe) begin
      if (pair_target == `ASRD_DIFF_UNI_W) begin
        unipolar_pair_config <= {shift[6:0], din_lvl} & `ASRD_PAIR_USED_MASK;
      end else if (pair_target == `ASRD_DIFF_BIP_W) begin
        bipolar_pair_config  <= {shift[6:0], din_lvl} & `ASRD_PAIR_USED_MASK;
      end
    end
  end

  // Low nibble is masked on load so it never reaches the pair decode
  assign uni_diff_pair01 = unipolar_pair_config[7];
  assign uni_diff_pair23 = unipolar_pair_config[6];
  assign uni_diff_pair45 = unipolar_pair_config[5];
  assign uni_diff_pair67 = unipolar_pair_config[4];

  ////////////////////////////////////////////////////////////////////////////
  // Reference and conversion sequencer, counted on serial-clock rises

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seq_state         <= asrd_pkg::ASRD_IDLE;
      cyc_cnt           <= 9'd0;
      conv_start        <= 1'b0;
      temp_result_ready <= 1'b0;
    end else begin
      conv_start        <= 1'b0;
      temp_result_ready <= 1'b0;
      unique case (seq_state)
        asrd_pkg::ASRD_IDLE: begin
          cyc_cnt <= 9'd0;
          if (conv_request && conv_clock_select == `ASRD_CKSEL_EXT) begin
            if (conv_is_temp) begin
              seq_state <= asrd_pkg::ASRD_TSET;
            end else if (ref_is_internal(ref_select) && !ref_warm) begin
              seq_state <= asrd_pkg::ASRD_WAKE;
            end else begin
              seq_state  <= asrd_pkg::ASRD_CONV;
              conv_start <= 1'b1;
            end
          end
        end
        asrd_pkg::ASRD_WAKE: begin
          if (sclk_rise) begin
            if (cyc_cnt == `ASRD_REF_WAKE_CYC - 9'd1) begin
              seq_state  <= asrd_pkg::ASRD_CONV;
              conv_start <= 1'b1;
              cyc_cnt    <= 9'd0;
            end else begin
              cyc_cnt <= cyc_cnt + 9'd1;
            end
          end
        end
        asrd_pkg::ASRD_CONV: begin
          if (scan_done) begin
            seq_state <= asrd_pkg::ASRD_IDLE;
          end
        end
        asrd_pkg::ASRD_TSET: begin
          if (sclk_rise) begin
            if (cyc_cnt == `ASRD_TEMP_SETTLE_CYC - 9'd1) begin
              seq_state  <= asrd_pkg::ASRD_TCONV;
              conv_start <= 1'b1;
              cyc_cnt    <= 9'd0;
            end else begin
              cyc_cnt <= cyc_cnt + 9'd1;
            end
          end
        end
        asrd_pkg::ASRD_TCONV: begin
          if (sclk_rise) begin
            if (cyc_cnt == `ASRD_TEMP_CONV_CYC - 9'd1) begin
              seq_state         <= asrd_pkg::ASRD_IDLE;
              temp_result_ready <= 1'b1;
              cyc_cnt           <= 9'd0;
            end else begin
              cyc_cnt <= cyc_cnt + 9'd1;
            end
          end
        end
        default: begin
          seq_state <= asrd_pkg::ASRD_IDLE;
        end
      endcase
    end
  end

  // Reference stays warm only while a conversion that needs it runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ref_warm <= 1'b0;
    end else if ((seq_state == asrd_pkg::ASRD_CONV && scan_done) ||
                 (seq_state == asrd_pkg::ASRD_TCONV && sclk_rise &&
                  cyc_cnt == `ASRD_TEMP_CONV_CYC - 9'd1)) begin
      ref_warm <= 1'b0;
    end else if (conv_start && (ref_is_internal(ref_select) ||
                                seq_state == asrd_pkg::ASRD_TCONV)) begin
      ref_warm <= 1'b1;
    end
  end

  always_comb begin
    int_ref_on = 1'b0;
    unique case (seq_state)
      asrd_pkg::ASRD_TSET, asrd_pkg::ASRD_TCONV: int_ref_on = 1'b1;
      asrd_pkg::ASRD_WAKE:                       int_ref_on = 1'b1;
      asrd_pkg::ASRD_CONV:                       int_ref_on = ref_is_internal(ref_select);
      default:                                   int_ref_on = 1'b0;
    endcase
  end

  assign busy = (seq_state != asrd_pkg::ASRD_IDLE);
endmodule // asrd_ctrl

// *** src/asrd_consts.svh ***
/*
  Constants for the setup, reference and channel-pair control block.
  Assumes inclusion by bare name from files under src/.
*/
`ifndef ASRD_CONSTS_SVH
`define ASRD_CONSTS_SVH

// Setup byte field positions
`define ASRD_SETUP_CKSEL_HI   5
`define ASRD_SETUP_CKSEL_LO   4
`define ASRD_SETUP_REFSEL_HI  3
`define ASRD_SETUP_REFSEL_LO  2
`define ASRD_SETUP_DIFF_HI    1
`define ASRD_SETUP_DIFF_LO    0

// Field values
`define ASRD_CKSEL_EXT        2'h3
`define ASRD_CKSEL_RESET      2'h2
`define ASRD_REFSEL_INT       2'h0
`define ASRD_REFSEL_EXT_SE    2'h1
`define ASRD_REFSEL_DEFAULT   2'h2
`define ASRD_REFSEL_EXT_DIFF  2'h3
`define ASRD_DIFF_UNI         2'h3
`define ASRD_DIFF_UNI_W       2'h2
`define ASRD_DIFF_BIP_W       2'h3

// Channel-pair register reset and used bits
`define ASRD_PAIR_RESET       8'h00
`define ASRD_PAIR_USED_MASK   8'hF0

// Delays in external serial-clock cycles
`define ASRD_REF_WAKE_CYC     9'd218
`define ASRD_TEMP_SETTLE_CYC  9'd244
`define ASRD_TEMP_CONV_CYC    9'd188

// Highest external conversion clock in kHz, reference clock in kHz
`define ASRD_EXT_CLK_MAX_KHZ  3600
`define ASRD_REF_CLK_KHZ      200000

`endif

// *** src/asrd_pkg.sv ***
/*
  Types for the setup, reference and channel-pair control block.
  Assumes nothing of its surroundings.
*/
package asrd_pkg;

  typedef enum logic [2:0] {
    ASRD_IDLE   = 3'h0,
    ASRD_WAKE   = 3'h1,
    ASRD_CONV   = 3'h3,
    ASRD_TSET   = 3'h2,
    ASRD_TCONV  = 3'h6
  } asrd_seq_t;

  typedef enum logic [1:0] {
    ASRD_RX_CMD  = 2'h0,
    ASRD_RX_DATA = 2'h1
  } asrd_rx_t;

endpackage

// *** src/asrd_sync.sv ***
/*
  Two-flop synchroniser with rise and fall detect on the synchronised level.
  Assumes an asynchronous input and one clock domain.
*/
`timescale 1ns/1ps
module asrd_sync (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~last;
  assign fall  = ~sync & last;
endmodule // asrd_sync

// *** sim/asrd_ctrl_chk.sv ***
/* Port checker for asrd_ctrl.
   Assumes binding to every asrd_ctrl instance. */
`timescale 1ns/1ps
module asrd_ctrl_chk (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       setup_strobe,
  input wire logic [7:0] setup_byte,
  input wire logic       conv_request,
  input wire logic       conv_is_temp,
  input wire logic       cmd_byte_valid,
  input wire logic       conv_start,
  input wire logic       int_ref_on,
  input wire logic       ref_pin_is_input,
  input wire logic [1:0] conv_clock_select,
  input wire logic [7:0] unipolar_pair_config,
  input wire logic [7:0] bipolar_pair_config,
  input wire logic       uni_diff_pair01,
  input wire logic       uni_diff_pair23,
  input wire logic       uni_diff_pair45,
  input wire logic       uni_diff_pair67,
  input wire logic       busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_req; conv_request && !busy; endsequence
  sequence s_ext_req; s_req ##0 conv_clock_select == 2'h3; endsequence
  property p_nib; (unipolar_pair_config[3:0] | bipolar_pair_config[3:0]) == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("pair low nibble set");
  property p_map; {uni_diff_pair01, uni_diff_pair23, uni_diff_pair45, uni_diff_pair67}
    == unipolar_pair_config[7:4]; endproperty
  a_map: assert property (p_map) else $error("pair bits mismatch");
  property p_pin; setup_strobe |=> ref_pin_is_input == !$past(setup_byte[2]); endproperty
  a_pin: assert property (p_pin) else $error("ref pin role wrong");
  property p_ck; setup_strobe |=> conv_clock_select == $past(setup_byte[5:4]); endproperty
  a_ck: assert property (p_ck) else $error("clock mode not taken");
  property p_keep; setup_strobe && !setup_byte[1] |=> $stable(unipolar_pair_config)
    && $stable(bipolar_pair_config); endproperty
  a_keep: assert property (p_keep) else $error("pair register changed");
  property p_temp; s_ext_req ##0 conv_is_temp |=> int_ref_on && busy; endproperty
  a_temp: assert property (p_temp) else $error("reference not forced");
  property p_ext; s_ext_req ##0 !conv_is_temp && !ref_pin_is_input |=> conv_start; endproperty
  a_ext: assert property (p_ext) else $error("external ref delayed");
  property p_load; $changed(unipolar_pair_config) || $changed(bipolar_pair_config)
    |-> !cmd_byte_valid; endproperty
  a_load: assert property (p_load) else $error("data byte seen as command");
  property p_refuse; s_req ##0 conv_clock_select != 2'h3 |=> !busy [*2]; endproperty
  a_refuse: assert property (p_refuse) else $error("request taken off mode");
endmodule // asrd_ctrl_chk
bind asrd_ctrl asrd_ctrl_chk u_chk (.*);

// *** sim/asrd_host.sv ***
/* Host model driving the serial link pins.
   Assumes the 200 MHz ref_clk; sclk period 32 cycles, still outside frames. */
`timescale 1ns/1ps
module asrd_host (
  input wire logic ref_clk,
  output logic     sclk_pin,
  output logic     cs_n_pin,
  output logic     din_pin
);
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    din_pin = 1'b1;
  end
  task automatic half();
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic tick(input logic d);
    din_pin <= d;
    half();
    sclk_pin <= 1'b1;
    half();
    sclk_pin <= 1'b0;
  endtask
  task automatic frame_open();
    @(posedge ref_clk);
    cs_n_pin <= 1'b0;
    half();
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(b[i]);
  endtask
  task automatic frame_close();
    half();
    cs_n_pin <= 1'b1;
    din_pin <= ~din_pin;
  endtask
endmodule // asrd_host

// *** sim/adc_setup_reference_diffsel_tb_top.sv ***
/* Self-checking bench for asrd_ctrl with a host model on the serial pins.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module adc_setup_reference_diffsel_tb_top;
  logic ref_clk, resetn, sclk_pin, cs_n_pin, din_pin, setup_strobe, conv_request;
  logic conv_is_temp, scan_done, cmd_byte_valid, conv_start, temp_result_ready, busy;
  logic int_ref_on, ref_pin_is_input, seen_st, seen_rd, seen_cmd;
  logic uni_diff_pair01, uni_diff_pair23, uni_diff_pair45, uni_diff_pair67;
  logic [1:0]  conv_clock_select;
  logic [7:0]  setup_byte, cmd_byte, unipolar_pair_config, bipolar_pair_config, cmd_val;
  logic [31:0] rnd;
  int          errors, comparisons, rises, st_at, rd_at;
  asrd_ctrl u_dut (.*);
  asrd_host u_host (.ref_clk(ref_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .din_pin(din_pin));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge sclk_pin) rises++;
  always @(posedge ref_clk) begin
    if (conv_start) begin seen_st <= 1'b1; st_at <= rises; end
    if (temp_result_ready) begin seen_rd <= 1'b1; rd_at <= rises; end
    if (cmd_byte_valid) begin seen_cmd <= 1'b1; cmd_val <= cmd_byte; end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic setup(input logic [1:0] ck, input logic [1:0] rs, input logic [1:0] ps);
    @(posedge ref_clk);
    setup_byte <= {2'h1, ck, rs, ps};
    setup_strobe <= 1'b1;
    @(posedge ref_clk);
    setup_strobe <= 1'b0;
  endtask
  task automatic pair_frame(input logic [1:0] ck, rs, ps, input logic [7:0] d);
    logic [7:0] u0, b0;
    u0 = unipolar_pair_config;
    b0 = bipolar_pair_config;
    seen_cmd = 1'b0;
    u_host.frame_open();
    setup(ck, rs, ps);
    u_host.put_byte(d);
    u_host.frame_close();
    repeat (8) @(posedge ref_clk);
    check(unipolar_pair_config, ps == 2'h2 ? d & 8'hF0 : u0);
    check(bipolar_pair_config, ps == 2'h3 ? d & 8'hF0 : b0);
    check({seen_cmd, cmd_val & {8{!ps[1]}}}, {!ps[1], d & {8{!ps[1]}}});
    check({uni_diff_pair01, uni_diff_pair23, uni_diff_pair45, uni_diff_pair67,
      ref_pin_is_input, conv_clock_select}, {unipolar_pair_config[7:4], !rs[0], ck});
  endtask
  task automatic conv(input logic t, input int exp_st, input int exp_rd);
    seen_st = 1'b0;
    seen_rd = 1'b0;
    rises = 0;
    @(posedge ref_clk);
    conv_request <= 1'b1;
    conv_is_temp <= t;
    @(posedge ref_clk);
    conv_request <= 1'b0;
    repeat (4) @(posedge ref_clk);
    u_host.frame_open();
    for (int k = 0; k < 600 && !(t ? seen_rd : seen_st); k++) u_host.tick(rnd[k % 32]);
    u_host.frame_close();
    if (!(t ? seen_rd : seen_st)) begin
      check(24'h0, 24'h1);
      test_done();
    end
    check(24'(st_at), 24'(exp_st));
    if (t) check(24'(rd_at), 24'(exp_rd));
    scan_done <= 1'b1;
    @(posedge ref_clk);
    scan_done <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(int_ref_on, 1'b0);
    $display("conversion test done");
  endtask
  initial begin
    {resetn, setup_strobe, conv_request, conv_is_temp, scan_done} = 5'h0;
    setup_byte = 8'h00;
    rnd = 32'h00017212;
    errors = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({unipolar_pair_config, bipolar_pair_config, conv_clock_select, ref_pin_is_input},
      {16'h0, 2'h2, 1'b1});
    seen_st = 1'b0;
    conv_request <= 1'b1;
    @(posedge ref_clk);
    conv_request <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check({seen_st, busy}, 2'h0);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      pair_frame(rnd[9:8], rnd[11:10], i[1:0], i == 0 ? 8'hFF : i == 1 ? 8'h0F :
        i == 2 ? 8'hCF : rnd[7:0]);
    end
    $display("pair test done");
    setup(2'h3, 2'h0, 2'h0);
    conv(1'b1, 244, 432);
    conv(1'b0, 218, 0);
    setup(2'h3, 2'h1, 2'h0);
    conv(1'b0, 0, 0);
    setup(2'h3, 2'h3, 2'h0);
    conv(1'b1, 244, 432);
    setup(2'h3, 2'h2, 2'h1);
    conv(1'b0, 218, 0);
    test_done();
  end
endmodule // adc_setup_reference_diffsel_tb_top
